// ---- inc/pmrc_regs.svh ----
// Timing counts, reset values and fixed addresses of the power-mode and reset controller.
//
// Contract
// - Light sleep stops the core clock; wake only restores it.
// - Light sleep suspends execution until reset or interrupt; peripherals keep running.
// - Deep sleep stops all clocks but the RC oscillator, gated unless watchdog clock.
// - Deep sleep shuts analog, flash standby; watchdog oscillator and brown-out may stay.
// - Deep sleep wakes on reset, GPIO, watchdog, USB, RTC or serial interrupts.
// - Serial port wakes deep modes only in low-frequency, synchronous or clear-to-send mode.
// - Power-down stops all clocks but selected watchdog oscillator; analog and flash off.
// - Power-down wakes on reset, GPIO, watchdog, USB, RTC or serial interrupts.
// - Deepest power-down powers only wake pin and always-on domain; wakes on pin or RTC.
// - Entry into deepest power-down is refused while the lock bit is set.
// - Wake pin is held high in deepest power-down; low wakes the device.
// - Pin, watchdog, power-on and brown-out resets merge into one chip reset.
// - On reset release the core starts fetching at address zero.
// - A reset pin low pulse of at least 50 ns resets and wakes.
// - The reset pin is ignored in deepest power-down and kept high outside.
// - Brown-out below the selected interrupt level raises an interrupt and a flag.
// - Brown-out below the selected one of two reset levels forces chip reset.
// - Reset pin low selects boundary scan, high selects serial debug; debug off in reset.
// - The test access port offers boundary scan only, never debug access.
// - After any reset or deepest power-down wake, run from the RC oscillator.
`ifndef PMRC_REGS_SVH
`define PMRC_REGS_SVH

`define PMRC_CLK_PERIOD_PS 5000
`define PMRC_RST_PULSE_NS 50
`define PMRC_RST_PULSE_CYC ((`PMRC_RST_PULSE_NS * 1000 + `PMRC_CLK_PERIOD_PS - 1) / `PMRC_CLK_PERIOD_PS)
`define PMRC_RST_HOLD_CYC 16
`define PMRC_SCAN_SETUP_US 250
`define PMRC_BOOT_ADDR 32'h0000_0000
`define PMRC_SYNC_DEPTH 2

`endif

// ---- inc/pmrc_pkg.sv ----
// Types shared by the power-mode and reset controller modules.
package pmrc_pkg;
    typedef enum logic [2:0] {PMRC_ACTIVE, PMRC_SLEEP, PMRC_DEEP_SLEEP, PMRC_POWER_DOWN,
        PMRC_DEEP_PD} pmrc_mode_type;
    typedef enum logic [1:0] {PMRC_REQ_SLEEP, PMRC_REQ_DEEP_SLEEP, PMRC_REQ_POWER_DOWN,
        PMRC_REQ_DEEP_PD} pmrc_req_type;
endpackage

// ---- inc/pmrc_rst_if.sv ----
// Reset sources and merged chip reset between the controller and its reset merger.
`timescale 1ns/1ps
interface pmrc_rst_if;
    logic pin_rst;
    logic wdt_rst;
    logic por_rst;
    logic bod_rst;
    logic wake_rst;
    logic chip_rst;
    logic release_pulse;
    modport merge (input pin_rst, input wdt_rst, input por_rst, input bod_rst,
        input wake_rst, output chip_rst, output release_pulse);
    modport ctrl (output pin_rst, output wdt_rst, output por_rst, output bod_rst,
        output wake_rst, input chip_rst, input release_pulse);
endinterface

// ---- logic/pmrc_input_sync.sv ----
// Two-flip-flop synchronisers for a vector of asynchronous inputs.
`timescale 1ns/1ps
`include "pmrc_regs.svh"
module pmrc_input_sync #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    initial begin
        if (WIDTH < 1) begin
            $error("pmrc_input_sync: WIDTH must be at least 1.");
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1;
            logic stage2;
            logic next_stage1;
            logic next_stage2;
            always_comb begin
                next_stage1 = async_in[i];
                next_stage2 = stage1;
            end
            always_ff @(posedge clk) begin
                if (rst) begin
                    stage1 <= RESET_VAL[i];
                    stage2 <= RESET_VAL[i];
                end else begin
                    stage1 <= next_stage1;
                    stage2 <= next_stage2;
                end
            end
            assign sync_out[i] = stage2;
        end
    endgenerate
endmodule

// ---- logic/pmrc_reset_merge.sv ----
// Merges all reset sources into one stretched chip reset.
`timescale 1ns/1ps
`include "pmrc_regs.svh"
module pmrc_reset_merge #(
    parameter int HOLD_CYC = `PMRC_RST_HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst,
    pmrc_rst_if.merge rif
);
    initial begin
        if (HOLD_CYC < 1 || HOLD_CYC > 255) begin
            $error("pmrc_reset_merge: HOLD_CYC must be 1 to 255.");
        end
    end

    logic [7:0] hold_cnt;
    logic chip_rst;
    logic release_pulse;
    logic [7:0] next_hold_cnt;
    logic next_chip_rst;
    logic next_release_pulse;
    logic any_src;

    always_comb begin
        any_src = rif.pin_rst | rif.wdt_rst | rif.por_rst | rif.bod_rst | rif.wake_rst;
        next_hold_cnt = hold_cnt;
        next_chip_rst = chip_rst;
        next_release_pulse = 1'b0;
        if (any_src) begin
            next_hold_cnt = 8'(HOLD_CYC);
            next_chip_rst = 1'b1;
        end else if (hold_cnt != 8'h00) begin
            next_hold_cnt = hold_cnt - 8'h01;
        end else if (chip_rst) begin
            next_chip_rst = 1'b0;
            next_release_pulse = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hold_cnt <= 8'(HOLD_CYC);
            chip_rst <= 1'b1;
            release_pulse <= 1'b0;
        end else begin
            hold_cnt <= next_hold_cnt;
            chip_rst <= next_chip_rst;
            release_pulse <= next_release_pulse;
        end
    end

    assign rif.chip_rst = chip_rst;
    assign rif.release_pulse = release_pulse;

    src_gives_rst_a: assert property (@(posedge clk) disable iff (rst)
        any_src |=> chip_rst)
        else $error("A reset source did not raise chip reset.");
endmodule

// ---- logic/pmrc_top.sv ----
// Power-mode sequencer, reset merging, brown-out and test port selection.
`timescale 1ns/1ps
`include "pmrc_regs.svh"
module pmrc_top #(
    parameter int RST_PULSE_CYC = `PMRC_RST_PULSE_CYC,
    parameter int RST_HOLD_CYC = `PMRC_RST_HOLD_CYC
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic RESET_PIN_N,
    input wire logic WAKE_PIN_N,
    input wire logic RTC_WAKE,
    input wire logic POWER_ON_RST,
    input wire logic [1:0] BROWNOUT_INT_BELOW,
    input wire logic [1:0] BROWNOUT_RST_BELOW,
    input wire logic BROWNOUT_INT_SEL,
    input wire logic BROWNOUT_RST_SEL,
    input wire logic BROWNOUT_RST_EN,
    input wire logic BROWNOUT_KEEP,
    input wire logic WDT_RESET,
    input wire logic WDT_IRQ,
    input wire logic WDT_OSC_KEEP,
    input wire logic WDT_CLK_IS_IRC,
    input wire logic GPIO_WAKE,
    input wire logic USB_ACT_IRQ,
    input wire logic RTC_IRQ,
    input wire logic SERIAL_IRQ,
    input wire logic UART_IRQ,
    input wire logic UART_WAKE_MODE,
    input wire logic IRQ_PENDING,
    input wire logic MODE_REQ,
    input wire logic [1:0] MODE_SEL,
    input wire logic DEEP_PD_LOCK,
    input wire logic CLK_SEL_WR,
    input wire logic [1:0] CLK_SEL_VAL,
    output logic CORE_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic CLK_SRC_EN,
    output logic IRC_RUN,
    output logic IRC_OUT_EN,
    output logic WDT_OSC_EN,
    output logic ANALOG_EN,
    output logic FLASH_ON,
    output logic FLASH_STANDBY,
    output logic BROWNOUT_EN,
    output logic CORE_POWER_ON,
    output logic [1:0] MAIN_CLK_SEL,
    output logic CHIP_RST,
    output logic FLASH_INIT,
    output logic CORE_START,
    output logic [31:0] BOOT_ADDR,
    output logic BROWNOUT_IRQ,
    output logic BROWNOUT_FLAG,
    output logic DEEP_PD_REFUSED,
    output logic TAP_SCAN_SEL,
    output logic SWD_EN,
    output logic TAP_DEBUG_EN
);
    initial begin
        if (RST_PULSE_CYC < 1 || RST_PULSE_CYC > 255) begin
            $error("pmrc_top: RST_PULSE_CYC must be 1 to 255.");
        end
    end

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync_raw;
    logic [NSYNC-1:0] sync_val;
    logic pin_n_s;
    logic wake_n_s;
    logic rtc_wake_s;
    logic por_s;
    logic [1:0] bod_int_s;
    logic [1:0] bod_rst_s;

    assign sync_raw = {RESET_PIN_N, WAKE_PIN_N, RTC_WAKE, POWER_ON_RST,
        BROWNOUT_INT_BELOW, BROWNOUT_RST_BELOW};

    pmrc_input_sync #(
        .WIDTH(NSYNC),
        .RESET_VAL(8'hc0)
    ) u_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .async_in(sync_raw),
        .sync_out(sync_val)
    );

    assign pin_n_s = sync_val[7];
    assign wake_n_s = sync_val[6];
    assign rtc_wake_s = sync_val[5];
    assign por_s = sync_val[4];
    assign bod_int_s = sync_val[3:2];
    assign bod_rst_s = sync_val[1:0];

    // ==========================================================
    // Reset pin pulse qualifier
    // ==========================================================
    pmrc_pkg::pmrc_mode_type mode;
    logic [7:0] low_cnt;
    logic [7:0] next_low_cnt;
    logic pin_rst;

    always_comb begin
        next_low_cnt = 8'h00;
        if (!pin_n_s && mode != pmrc_pkg::PMRC_DEEP_PD) begin
            next_low_cnt = (low_cnt == 8'(RST_PULSE_CYC)) ? low_cnt : low_cnt + 8'h01;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            low_cnt <= 8'h00;
        end else begin
            low_cnt <= next_low_cnt;
        end
    end

    // A low pulse held for the minimum width becomes a reset that wakes.
    assign pin_rst = (low_cnt == 8'(RST_PULSE_CYC));

    // ==========================================================
    // Reset merging
    // ==========================================================
    pmrc_rst_if rif ();
    logic bod_rst_hit;
    logic wake_rst;

    assign bod_rst_hit = BROWNOUT_RST_EN && bod_rst_s[BROWNOUT_RST_SEL];
    assign rif.pin_rst = pin_rst;
    assign rif.wdt_rst = WDT_RESET && mode != pmrc_pkg::PMRC_DEEP_PD;
    assign rif.por_rst = por_s;
    assign rif.bod_rst = bod_rst_hit && mode != pmrc_pkg::PMRC_DEEP_PD;
    assign rif.wake_rst = wake_rst;

    pmrc_reset_merge #(
        .HOLD_CYC(RST_HOLD_CYC)
    ) u_merge (
        .clk(CLK),
        .rst(SYS_RST),
        .rif(rif)
    );

    // ==========================================================
    // Power-mode sequencer
    // ==========================================================
    pmrc_pkg::pmrc_mode_type next_mode;
    logic next_wake_rst;
    logic next_refused;
    logic refused;
    logic deep_wake;
    logic uart_wake;

    assign uart_wake = UART_IRQ && UART_WAKE_MODE;
    assign deep_wake = GPIO_WAKE | WDT_IRQ | USB_ACT_IRQ | RTC_IRQ | SERIAL_IRQ | uart_wake;

    always_comb begin
        next_mode = mode;
        next_wake_rst = 1'b0;
        next_refused = 1'b0;
        case (mode)
            pmrc_pkg::PMRC_ACTIVE: begin
                if (MODE_REQ) begin
                    case (pmrc_pkg::pmrc_req_type'(MODE_SEL))
                        pmrc_pkg::PMRC_REQ_SLEEP: next_mode = pmrc_pkg::PMRC_SLEEP;
                        pmrc_pkg::PMRC_REQ_DEEP_SLEEP: next_mode = pmrc_pkg::PMRC_DEEP_SLEEP;
                        pmrc_pkg::PMRC_REQ_POWER_DOWN: next_mode = pmrc_pkg::PMRC_POWER_DOWN;
                        default: begin
                            if (DEEP_PD_LOCK) begin
                                next_refused = 1'b1;
                            end else begin
                                next_mode = pmrc_pkg::PMRC_DEEP_PD;
                            end
                        end
                    endcase
                end
            end
            pmrc_pkg::PMRC_SLEEP: begin
                if (IRQ_PENDING) begin
                    next_mode = pmrc_pkg::PMRC_ACTIVE;
                end
            end
            pmrc_pkg::PMRC_DEEP_SLEEP, pmrc_pkg::PMRC_POWER_DOWN: begin
                if (deep_wake) begin
                    next_mode = pmrc_pkg::PMRC_ACTIVE;
                end
            end
            default: begin
                if (!wake_n_s || rtc_wake_s) begin
                    next_mode = pmrc_pkg::PMRC_ACTIVE;
                    next_wake_rst = 1'b1;
                end
            end
        endcase
        if (rif.chip_rst && mode != pmrc_pkg::PMRC_DEEP_PD) begin
            next_mode = pmrc_pkg::PMRC_ACTIVE;
            next_refused = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mode <= pmrc_pkg::PMRC_ACTIVE;
            wake_rst <= 1'b0;
            refused <= 1'b0;
        end else begin
            mode <= next_mode;
            wake_rst <= next_wake_rst;
            refused <= next_refused;
        end
    end

    // ==========================================================
    // Clock selection
    // ==========================================================
    logic [1:0] clk_sel;
    logic [1:0] next_clk_sel;

    always_comb begin
        next_clk_sel = clk_sel;
        if (rif.chip_rst || wake_rst) begin
            next_clk_sel = 2'h0;
        end else if (CLK_SEL_WR && mode == pmrc_pkg::PMRC_ACTIVE) begin
            next_clk_sel = CLK_SEL_VAL;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            clk_sel <= 2'h0;
        end else begin
            clk_sel <= next_clk_sel;
        end
    end

    // ==========================================================
    // Clock, analog and power gating outputs
    // ==========================================================
    logic [10:0] gate;
    logic [10:0] next_gate;
    logic run_m;
    logic deep_m;
    logic pd_m;
    logic dpd_m;
    logic next_chip_rst_w;

    always_comb begin
        run_m = next_mode == pmrc_pkg::PMRC_ACTIVE || next_mode == pmrc_pkg::PMRC_SLEEP;
        deep_m = next_mode == pmrc_pkg::PMRC_DEEP_SLEEP;
        pd_m = next_mode == pmrc_pkg::PMRC_POWER_DOWN;
        dpd_m = next_mode == pmrc_pkg::PMRC_DEEP_PD;
        next_gate[0] = next_mode == pmrc_pkg::PMRC_ACTIVE;
        next_gate[1] = run_m;
        next_gate[2] = run_m;
        next_gate[3] = run_m || deep_m || next_chip_rst_w;
        next_gate[4] = run_m || (deep_m && WDT_CLK_IS_IRC);
        next_gate[5] = run_m || ((deep_m || pd_m) && WDT_OSC_KEEP);
        next_gate[6] = run_m;
        next_gate[7] = run_m || deep_m;
        next_gate[8] = deep_m;
        next_gate[9] = !dpd_m && (run_m || BROWNOUT_KEEP);
        next_gate[10] = !dpd_m;
    end

    assign next_chip_rst_w = rif.chip_rst;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            gate <= 11'h40f;
        end else begin
            gate <= next_gate;
        end
    end

    assign CORE_CLK_EN = gate[0];
    assign PERIPH_CLK_EN = gate[1];
    assign CLK_SRC_EN = gate[2];
    assign IRC_RUN = gate[3];
    assign IRC_OUT_EN = gate[4];
    assign WDT_OSC_EN = gate[5];
    assign ANALOG_EN = gate[6];
    assign FLASH_ON = gate[7];
    assign FLASH_STANDBY = gate[8];
    assign BROWNOUT_EN = gate[9];
    assign CORE_POWER_ON = gate[10];
    assign MAIN_CLK_SEL = clk_sel;
    assign DEEP_PD_REFUSED = refused;

    // ==========================================================
    // Reset, boot, brown-out and test port outputs
    // ==========================================================
    logic [5:0] misc;
    logic [5:0] next_misc;

    always_comb begin
        next_misc[0] = rif.chip_rst;
        next_misc[1] = rif.chip_rst;
        next_misc[2] = rif.release_pulse;
        next_misc[3] = bod_int_s[BROWNOUT_INT_SEL] && gate[9];
        next_misc[4] = !pin_n_s;
        next_misc[5] = pin_n_s && !rif.chip_rst;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            misc <= 6'h03;
        end else begin
            misc <= next_misc;
        end
    end

    assign CHIP_RST = misc[0];
    assign FLASH_INIT = misc[1];
    assign CORE_START = misc[2];
    assign BOOT_ADDR = `PMRC_BOOT_ADDR;
    assign BROWNOUT_IRQ = misc[3];
    assign BROWNOUT_FLAG = misc[3];
    assign TAP_SCAN_SEL = misc[4];
    assign SWD_EN = misc[5];
    // The test access port never carries debug traffic.
    assign TAP_DEBUG_EN = 1'b0;

    // ==========================================================
    // Assertions
    // ==========================================================
    sleep_core_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        mode == pmrc_pkg::PMRC_SLEEP |-> ##1 !CORE_CLK_EN || $past(next_mode) !=
        pmrc_pkg::PMRC_SLEEP)
        else $error("Core clock running in light sleep.");

    sleep_irq_wake_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        mode == pmrc_pkg::PMRC_SLEEP && IRQ_PENDING |=> mode == pmrc_pkg::PMRC_ACTIVE
        && CORE_CLK_EN)
        else $error("Interrupt did not end light sleep.");

    deep_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        mode == pmrc_pkg::PMRC_DEEP_SLEEP && $past(mode) == pmrc_pkg::PMRC_DEEP_SLEEP
        && !rif.chip_rst |-> !PERIPH_CLK_EN && !ANALOG_EN && FLASH_STANDBY)
        else $error("Deep sleep left a clock or analog block on.");

    uart_wake_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        mode == pmrc_pkg::PMRC_POWER_DOWN && !rif.chip_rst && UART_IRQ &&
        !UART_WAKE_MODE && !GPIO_WAKE && !WDT_IRQ && !USB_ACT_IRQ && !RTC_IRQ &&
        !SERIAL_IRQ |=> mode == pmrc_pkg::PMRC_POWER_DOWN)
        else $error("Serial port woke power-down in a mode that cannot.");

    dpd_lock_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        mode == pmrc_pkg::PMRC_ACTIVE && MODE_REQ && MODE_SEL == 2'h3 && DEEP_PD_LOCK
        |=> mode != pmrc_pkg::PMRC_DEEP_PD && (DEEP_PD_REFUSED || $past(rif.chip_rst)))
        else $error("Deepest power-down entered while locked.");

    dpd_wake_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        mode == pmrc_pkg::PMRC_DEEP_PD && !wake_n_s |=> mode == pmrc_pkg::PMRC_ACTIVE
        ##[1:3] CHIP_RST)
        else $error("Wake pin did not wake and reset the device.");

    pin_width_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(pin_rst) |-> $past(low_cnt) == 8'(RST_PULSE_CYC - 1) ##[1:2] rif.chip_rst)
        else $error("Reset pin pulse width not honoured.");

    dpd_pin_ignored_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        mode == pmrc_pkg::PMRC_DEEP_PD && $past(mode) == pmrc_pkg::PMRC_DEEP_PD |->
        low_cnt == 8'h00)
        else $error("Reset pin counted during deepest power-down.");

    swd_in_reset_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        rif.chip_rst |=> !SWD_EN)
        else $error("Serial debug enabled during reset.");

    irc_after_reset_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $fell(rif.chip_rst) |-> MAIN_CLK_SEL == 2'h0 && IRC_RUN)
        else $error("Reset did not return to the RC oscillator.");
endmodule

// ---- sim/pmrc_pin_model.sv ----
// External pin model: reset pin and wake pin, both with pull-ups.
`timescale 1ns/1ps
module pmrc_pin_model (
    input wire logic clk,
    output logic reset_pin_n,
    output logic wake_pin_n
);
    // ==========================================================
    // Pins
    // Released pins rest at their pull-up level.
    initial begin
        reset_pin_n = 1'b1;
        wake_pin_n = 1'b1;
    end
    // A test rig pulls the reset pin low and later releases it.
    task automatic set_rst(input logic v);
        @(posedge clk);
        reset_pin_n <= v;
    endtask
    task automatic set_wake(input logic v);
        @(posedge clk);
        wake_pin_n <= v;
    endtask
endmodule

// ---- sim/tb_pmrc_top.sv ----
// Self-checking bench for the power-mode and reset controller.
`timescale 1ns/1ps
module tb_pmrc_top;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic RESET_PIN_N, WAKE_PIN_N;
    logic GPIO_WAKE = 1'b0, WDT_IRQ = 1'b0, USB_ACT_IRQ = 1'b0, RTC_IRQ = 1'b0;
    logic SERIAL_IRQ = 1'b0;
    logic RTC_WAKE = 1'b0, POWER_ON_RST = 1'b0, WDT_RESET = 1'b0, MODE_REQ = 1'b0;
    logic [1:0] BROWNOUT_INT_BELOW = 2'h0, BROWNOUT_RST_BELOW = 2'h0;
    logic [1:0] MODE_SEL = 2'h0, CLK_SEL_VAL = 2'h0;
    logic BROWNOUT_INT_SEL = 1'b0, BROWNOUT_RST_SEL = 1'b0, BROWNOUT_RST_EN = 1'b0;
    logic BROWNOUT_KEEP = 1'b0, WDT_OSC_KEEP = 1'b0, WDT_CLK_IS_IRC = 1'b0;
    logic UART_IRQ = 1'b0, UART_WAKE_MODE = 1'b0, IRQ_PENDING = 1'b0;
    logic DEEP_PD_LOCK = 1'b0, CLK_SEL_WR = 1'b0, refused_seen = 1'b0;
    logic CORE_CLK_EN, PERIPH_CLK_EN, CLK_SRC_EN, IRC_RUN, IRC_OUT_EN, WDT_OSC_EN;
    logic ANALOG_EN, FLASH_ON, FLASH_STANDBY, BROWNOUT_EN, CORE_POWER_ON, CHIP_RST;
    logic FLASH_INIT, CORE_START, BROWNOUT_IRQ, BROWNOUT_FLAG, DEEP_PD_REFUSED;
    logic TAP_SCAN_SEL, SWD_EN, TAP_DEBUG_EN;
    logic [1:0] MAIN_CLK_SEL;
    logic [31:0] BOOT_ADDR;
    int mismatches = 0, n_tests = 0, cycles = 0;
    always #2.5 CLK = ~CLK;
    pmrc_pin_model pins (.clk(CLK), .reset_pin_n(RESET_PIN_N), .wake_pin_n(WAKE_PIN_N));
    pmrc_top dut (.CLK, .SYS_RST, .RESET_PIN_N, .WAKE_PIN_N, .RTC_WAKE, .POWER_ON_RST,
        .BROWNOUT_INT_BELOW, .BROWNOUT_RST_BELOW, .BROWNOUT_INT_SEL, .BROWNOUT_RST_SEL,
        .BROWNOUT_RST_EN, .BROWNOUT_KEEP, .WDT_RESET, .WDT_IRQ, .WDT_OSC_KEEP,
        .WDT_CLK_IS_IRC, .GPIO_WAKE, .USB_ACT_IRQ, .RTC_IRQ, .SERIAL_IRQ, .UART_IRQ,
        .UART_WAKE_MODE, .IRQ_PENDING, .MODE_REQ, .MODE_SEL, .DEEP_PD_LOCK, .CLK_SEL_WR,
        .CLK_SEL_VAL, .CORE_CLK_EN, .PERIPH_CLK_EN, .CLK_SRC_EN, .IRC_RUN, .IRC_OUT_EN,
        .WDT_OSC_EN, .ANALOG_EN, .FLASH_ON, .FLASH_STANDBY, .BROWNOUT_EN, .CORE_POWER_ON,
        .MAIN_CLK_SEL, .CHIP_RST, .FLASH_INIT, .CORE_START, .BOOT_ADDR, .BROWNOUT_IRQ,
        .BROWNOUT_FLAG, .DEEP_PD_REFUSED, .TAP_SCAN_SEL, .SWD_EN, .TAP_DEBUG_EN);
    // ==========================================================
    // Helpers
    always @(posedge CLK) begin
        cycles++;
        refused_seen <= refused_seen | (DEEP_PD_REFUSED === 1'b1);
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_start();
        for (int i = 0; i < 200 && CORE_START !== 1'b1; i++) cyc(1);
        chk(CORE_START, 1'b1);
        cyc(1);
        chk(CHIP_RST, 1'b0);
    endtask
    task automatic req(input logic [1:0] sel);
        @(posedge CLK);
        MODE_REQ <= 1'b1;
        MODE_SEL <= sel;
        @(posedge CLK);
        MODE_REQ <= 1'b0;
        cyc(3);
    endtask
    // ==========================================================
    // Tests
    task automatic t_sleep();
        req(2'h0);
        chk(CORE_CLK_EN, 1'b0);
        chk(PERIPH_CLK_EN, 1'b1);
        IRQ_PENDING <= 1'b1;
        cyc(3);
        chk(CORE_CLK_EN, 1'b1);
        IRQ_PENDING <= 1'b0;
        $display("sleep test done");
    endtask
    task automatic t_deep();
        @(posedge CLK);
        CLK_SEL_WR <= 1'b1;
        CLK_SEL_VAL <= 2'h2;
        @(posedge CLK);
        CLK_SEL_WR <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            WDT_OSC_KEEP <= (i == 0);
            BROWNOUT_KEEP <= (i == 0);
            WDT_CLK_IS_IRC <= (i == 2);
            req(2'(i % 2 + 1));
            chk(PERIPH_CLK_EN, 1'b0);
            chk(ANALOG_EN, 1'b0);
            chk(WDT_OSC_EN, i == 0);
            chk(BROWNOUT_EN, i == 0);
            chk(i % 2 ? FLASH_ON : IRC_OUT_EN, i == 2);
            chk(FLASH_STANDBY, i % 2 == 0);
            {GPIO_WAKE, WDT_IRQ, USB_ACT_IRQ, RTC_IRQ, SERIAL_IRQ} <= 5'h1 << i;
            cyc(3);
            chk(CORE_CLK_EN, 1'b1);
            chk(MAIN_CLK_SEL, 2'h2);
            {GPIO_WAKE, WDT_IRQ, USB_ACT_IRQ, RTC_IRQ, SERIAL_IRQ} <= 5'h0;
        end
        req(2'h2);
        UART_IRQ <= 1'b1;
        cyc(4);
        chk(CORE_CLK_EN, 1'b0);
        UART_WAKE_MODE <= 1'b1;
        cyc(3);
        chk(CORE_CLK_EN, 1'b1);
        UART_IRQ <= 1'b0;
        $display("deep modes test done");
    endtask
    task automatic t_deep_pd();
        DEEP_PD_LOCK <= 1'b1;
        req(2'h3);
        chk(refused_seen, 1'b1);
        chk(CORE_POWER_ON, 1'b1);
        DEEP_PD_LOCK <= 1'b0;
        req(2'h3);
        chk(CORE_POWER_ON, 1'b0);
        pins.set_rst(1'b0);
        cyc(14);
        chk(CHIP_RST, 1'b0);
        pins.set_rst(1'b1);
        pins.set_wake(1'b0);
        cyc(4);
        pins.set_wake(1'b1);
        wait_start();
        chk(CORE_POWER_ON, 1'b1);
        chk(MAIN_CLK_SEL, 2'h0);
        req(2'h3);
        chk(CORE_POWER_ON, 1'b0);
        RTC_WAKE <= 1'b1;
        cyc(4);
        RTC_WAKE <= 1'b0;
        wait_start();
        chk(CORE_POWER_ON, 1'b1);
        $display("deepest power-down test done");
    endtask
    task automatic t_pin();
        req(2'h0);
        pins.set_rst(1'b0);
        cyc(5);
        pins.set_rst(1'b1);
        cyc(12);
        chk(CHIP_RST, 1'b0);
        pins.set_rst(1'b0);
        cyc(16);
        chk(CHIP_RST, 1'b1);
        chk(TAP_SCAN_SEL, 1'b1);
        chk(SWD_EN, 1'b0);
        pins.set_rst(1'b1);
        wait_start();
        chk(CORE_CLK_EN, 1'b1);
        chk(SWD_EN, 1'b1);
        $display("reset pin test done");
    endtask
    task automatic t_sources();
        for (int i = 0; i < 4; i++) begin
            @(posedge CLK);
            WDT_RESET <= (i == 0);
            POWER_ON_RST <= (i == 1);
            BROWNOUT_RST_EN <= 1'b1;
            BROWNOUT_RST_SEL <= (i == 3);
            BROWNOUT_RST_BELOW <= {i > 1, 1'b0};
            cyc(6);
            chk(CHIP_RST, i != 2);
            chk(FLASH_INIT, i != 2);
            WDT_RESET <= 1'b0;
            POWER_ON_RST <= 1'b0;
            BROWNOUT_RST_BELOW <= 2'h0;
            if (i != 2) wait_start();
        end
        BROWNOUT_INT_SEL <= 1'b1;
        BROWNOUT_INT_BELOW <= 2'h1;
        cyc(5);
        chk(BROWNOUT_IRQ, 1'b0);
        BROWNOUT_INT_BELOW <= 2'h2;
        cyc(5);
        chk({BROWNOUT_IRQ, BROWNOUT_FLAG}, 2'h3);
        $display("reset sources test done");
    endtask
    initial begin
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        wait_start();
        chk(BOOT_ADDR, 32'h0);
        chk({IRC_RUN, MAIN_CLK_SEL}, 3'h4);
        chk(TAP_DEBUG_EN, 1'b0);
        t_sleep();
        t_deep();
        t_deep_pd();
        t_pin();
        t_sources();
        print_verdict();
    end
endmodule
